// file: rtl/vpc_cfg.svh
`ifndef VPC_CFG_SVH
`define VPC_CFG_SVH

`define VPC_CLK_MHZ        100
`define VPC_IN_REACT_MS    3
`define VPC_GUARD_MS       3000
`define VPC_BLINK_MS       250
`define VPC_OUT_DLY_MIN    8'd1
`define VPC_OUT_DLY_MAX    8'd200

`define VPC_ADR_CTRL       8'h00
`define VPC_ADR_UPPER      8'h04
`define VPC_ADR_LOWER      8'h08
`define VPC_ADR_HYST       8'h0c
`define VPC_ADR_BLOW_MS    8'h10
`define VPC_ADR_OUT_DLY    8'h14
`define VPC_ADR_STATUS     8'h18
`define VPC_ADR_IRQ_STAT   8'h1c
`define VPC_ADR_IRQ_MASK   8'h20

`define VPC_CTRL_REG_EN    0
`define VPC_CTRL_MANUAL    1
`define VPC_CTRL_INT_BLOW  2

`define VPC_IRQ_PLOSS      0
`define VPC_IRQ_CONFLICT   1
`define VPC_IRQ_UPPER      2

`define VPC_RST_CTRL       3'h1
`define VPC_RST_UPPER      10'h1f4
`define VPC_RST_LOWER      10'h0c8
`define VPC_RST_HYST       10'h014
`define VPC_RST_BLOW_MS    16'h00c8
`define VPC_RST_OUT_DLY    8'h0a
`define VPC_ERR_PARAM_LOSS 8'h01

`endif

// file: rtl/vpc_pkg.sv
`default_nettype none
package vpc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SUCK,
    ST_BLOW_EXT,
    ST_BLOW_INT
  } vpc_state_t;

  typedef struct packed {
    logic blow;
    logic suck;
  } vpc_cmd_t;
endpackage : vpc_pkg
`default_nettype wire

// file: rtl/vpc_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface vpc_cmd_if;
  vpc_pkg::vpc_cmd_t raw;
  vpc_pkg::vpc_cmd_t clean;
  modport filt (input raw, output clean);
  modport core (output raw, input clean);
endinterface : vpc_cmd_if
`default_nettype wire

// file: rtl/vpc_in_filter.sv
`timescale 1ns/1ps
`default_nettype none
module vpc_in_filter #(
  parameter int FILT_CYC = 300000
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  vpc_cmd_if.filt  cmd
);
  localparam int CW = $clog2(FILT_CYC + 1);

  generate
    if (FILT_CYC < 1) begin : g_bad
      $error("FILT_CYC must be at least 1");
    end
  endgenerate

  logic [1:0] raw_v;
  logic [1:0] clean_v;
  assign raw_v = cmd.raw;
  assign cmd.clean = clean_v;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bit
      logic          s1_q;
      logic          s2_q;
      logic          out_q;
      logic [CW-1:0] cnt_q;
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= raw_v[g];
          s2_q <= s1_q;
        end
      end
      // Level must hold a full reaction time before it is accepted
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          cnt_q <= '0;
          out_q <= 1'b0;
        end else if (s2_q == out_q) begin
          cnt_q <= '0;
        end else if (cnt_q == CW'(FILT_CYC - 1)) begin
          cnt_q <= '0;
          out_q <= s2_q; // [RL10]
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
      assign clean_v[g] = out_q;
    end
  endgenerate
endmodule : vpc_in_filter
`default_nettype wire

// file: rtl/vpc_top.sv
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "vpc_cfg.svh"
// Operation
// [RL1] Both commands asserted: blowoff wins
// [RL2] Standby: both process LEDs off
// [RL3] Suction LED steady in suction, also regulating
// [RL4] Blowoff LED steady while venting
// [RL5] Rising vacuum: limit LEDs follow thresholds
// [RL6] Falling vacuum: limit LEDs clear with hysteresis
// [RL7] Manual mode: both limit LEDs flash
// [RL8] Limit LEDs from vacuum comparison only
// [RL9] Supply drop within 3 s: parameter-loss error
// [RL10] Command inputs react after about 3 ms
// [RL11] Signal output delay adjustable 1-200 ms
// [RL12] Serial mode: remote parameter writes accepted
// [RL13] Regulate pump between upper and minus 10%
// [RL14] Internal blowoff timed after suction exit
// [RL15] Pump runs while suction asserted
// [RL16] Commands synchronised before conflict resolution
module vpc_top #(
  parameter int VAC_W    = 10,
  parameter int MS_CYC   = `VPC_CLK_MHZ * 1000,
  parameter int FILT_CYC = `VPC_IN_REACT_MS * `VPC_CLK_MHZ * 1000
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_suction,
  input  wire logic             i_blowoff,
  input  wire logic [VAC_W-1:0] i_vacuum,
  input  wire logic             i_supply_ok,
  input  wire logic             i_serial_mode,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic                  o_pump_on,
  output logic                  o_vent_valve,
  output logic                  o_led_suction,
  output logic                  o_led_blowoff,
  output logic                  o_led_upper,
  output logic                  o_led_lower,
  output logic                  o_sw_out,
  output logic                  o_irq
);
  localparam int MCW = $clog2(MS_CYC + 1);

  generate
    if (VAC_W < 4 || VAC_W > 16 || MS_CYC < 1) begin : g_bad
      $error("VAC_W must be 4..16 and MS_CYC at least 1");
    end
  endgenerate

  function automatic logic wmask(input logic [3:0] s, input int b);
    wmask = s[b / 8];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `VPC_ADR_IRQ_MASK);
  endfunction

  // Command filtering and synchronisation
  vpc_cmd_if cmd ();
  assign cmd.raw = '{blow: i_blowoff, suck: i_suction};
  vpc_in_filter #(.FILT_CYC(FILT_CYC)) u_filt (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .cmd       (cmd)
  ); // [RL16]

  logic suck;
  logic blow;
  assign suck = cmd.clean.suck;
  assign blow = cmd.clean.blow;

  // Millisecond tick
  logic [MCW-1:0] ms_cnt_q;
  logic           ms_tick_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ms_cnt_q  <= '0;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= (ms_cnt_q == MCW'(MS_CYC - 1));
      ms_cnt_q  <= (ms_cnt_q == MCW'(MS_CYC - 1)) ? '0 : ms_cnt_q + 1'b1;
    end
  end

  // Parameter registers
  logic [2:0]       ctrl_q;
  logic [VAC_W-1:0] upper_q;
  logic [VAC_W-1:0] lower_q;
  logic [VAC_W-1:0] hyst_q;
  logic [15:0]      blow_ms_q;
  logic [7:0]       out_dly_q;
  logic [2:0]       irq_stat_q;
  logic [2:0]       irq_mask_q;
  logic [7:0]       err_code_q;

  // AXI4-Lite write path
  logic [7:0]  aw_addr_q;
  logic        aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_have_q;
  logic        wr_go;
  logic        wr_param;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_param = wr_go && i_serial_mode && (aw_addr_q <= `VPC_ADR_OUT_DLY)
                    && (aw_addr_q[1:0] == 2'b00); // [RL12]

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_q) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Parameters only accepted while the serial link is in charge; the interrupt mask is written at any time
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_q     <= `VPC_RST_CTRL;
      upper_q    <= VAC_W'(`VPC_RST_UPPER);
      lower_q    <= VAC_W'(`VPC_RST_LOWER);
      hyst_q     <= VAC_W'(`VPC_RST_HYST);
      blow_ms_q  <= `VPC_RST_BLOW_MS;
      out_dly_q  <= `VPC_RST_OUT_DLY;
      irq_mask_q <= 3'h0;
    end else begin
      if (wr_param && wmask(w_strb_q, 0)) begin
        unique case (aw_addr_q)
          `VPC_ADR_CTRL:    ctrl_q <= w_data_q[2:0];
          `VPC_ADR_UPPER:   upper_q <= VAC_W'(w_data_q[15:0]);
          `VPC_ADR_LOWER:   lower_q <= VAC_W'(w_data_q[15:0]);
          `VPC_ADR_HYST:    hyst_q <= VAC_W'(w_data_q[15:0]);
          `VPC_ADR_BLOW_MS: blow_ms_q <= w_data_q[15:0];
          `VPC_ADR_OUT_DLY: begin
            if (w_data_q[7:0] < `VPC_OUT_DLY_MIN) begin
              out_dly_q <= `VPC_OUT_DLY_MIN;
            end else if (w_data_q[7:0] > `VPC_OUT_DLY_MAX) begin
              out_dly_q <= `VPC_OUT_DLY_MAX;
            end else begin
              out_dly_q <= w_data_q[7:0]; // [RL11]
            end
          end
          default: ;
        endcase
      end
      if (wr_go && aw_addr_q == `VPC_ADR_IRQ_MASK && wmask(w_strb_q, 0)) begin
        irq_mask_q <= w_data_q[2:0];
      end
    end
  end

  // Parameter-loss guard: supply must hold for the guard time after a change
  logic [11:0] guard_ms_q;
  logic        guard_q;
  logic        ploss_ev;
  assign ploss_ev = guard_q && !i_supply_ok;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      guard_q    <= 1'b0;
      guard_ms_q <= 12'h000;
      err_code_q <= 8'h00;
    end else begin
      if (wr_param) begin
        guard_q    <= 1'b1;
        guard_ms_q <= 12'h000;
      end else if (ploss_ev) begin
        guard_q    <= 1'b0;
        err_code_q <= `VPC_ERR_PARAM_LOSS; // [RL9]
      end else if (guard_q && ms_tick_q) begin
        guard_ms_q <= guard_ms_q + 1'b1;
        if (guard_ms_q == 12'(`VPC_GUARD_MS - 1)) begin
          guard_q <= 1'b0;
        end
      end
    end
  end

  // Process state machine
  vpc_pkg::vpc_state_t state_q;
  logic [15:0]         bt_ms_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= vpc_pkg::ST_IDLE;
      bt_ms_q <= 16'h0000;
    end else begin
      if (ms_tick_q) begin
        bt_ms_q <= bt_ms_q + 1'b1;
      end
      unique case (state_q)
        vpc_pkg::ST_IDLE: begin
          if (blow) begin
            state_q <= vpc_pkg::ST_BLOW_EXT; // [RL1]
          end else if (suck) begin
            state_q <= vpc_pkg::ST_SUCK; // [RL15]
          end
        end
        vpc_pkg::ST_SUCK: begin
          bt_ms_q <= 16'h0000;
          if (blow) begin
            state_q <= vpc_pkg::ST_BLOW_EXT; // [RL1]
          end else if (!suck) begin
            state_q <= ctrl_q[`VPC_CTRL_INT_BLOW] ? vpc_pkg::ST_BLOW_INT
                                                  : vpc_pkg::ST_IDLE; // [RL14]
          end
        end
        vpc_pkg::ST_BLOW_EXT: begin
          if (!blow) begin
            state_q <= suck ? vpc_pkg::ST_SUCK : vpc_pkg::ST_IDLE;
          end
        end
        vpc_pkg::ST_BLOW_INT: begin
          if (blow) begin
            state_q <= vpc_pkg::ST_BLOW_EXT;
          end else if (suck) begin
            state_q <= vpc_pkg::ST_SUCK;
          end else if (bt_ms_q >= blow_ms_q) begin
            state_q <= vpc_pkg::ST_IDLE; // [RL14]
          end
        end
      endcase
    end
  end

  // Vacuum comparisons, widened so the margins added to the vacuum cannot wrap
  logic [VAC_W:0] vac_w;
  logic [VAC_W:0] up_w;
  logic [VAC_W:0] up_tenth_w;
  logic [VAC_W:0] lo_w;
  logic           above_up;
  logic           below_up_h;
  logic           above_lo;
  logic           below_lo_h;
  assign vac_w      = {1'b0, i_vacuum};
  assign up_w       = {1'b0, upper_q};
  assign up_tenth_w = {1'b0, upper_q} / (VAC_W + 1)'(10);
  assign lo_w       = {1'b0, lower_q};
  assign above_up   = vac_w > up_w;
  assign below_up_h = (vac_w + up_tenth_w) < up_w;
  assign above_lo   = vac_w > lo_w;
  assign below_lo_h = (vac_w + {1'b0, hyst_q}) < lo_w;

  // Pump with two-point regulation inside suction
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pump_on <= 1'b0;
    end else if (state_q != vpc_pkg::ST_SUCK || blow) begin
      o_pump_on <= 1'b0;
    end else if (!ctrl_q[`VPC_CTRL_REG_EN]) begin
      o_pump_on <= 1'b1; // [RL15]
    end else if (vac_w >= up_w) begin
      o_pump_on <= 1'b0; // [RL13]
    end else if (below_up_h || !o_pump_on && $past(state_q) != vpc_pkg::ST_SUCK) begin
      o_pump_on <= 1'b1; // [RL13]
    end
  end

  // Process LEDs and vent valve
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_led_suction <= 1'b0;
      o_led_blowoff <= 1'b0;
      o_vent_valve  <= 1'b0;
    end else begin
      o_led_suction <= (state_q == vpc_pkg::ST_SUCK); // [RL2] [RL3]
      o_led_blowoff <= (state_q == vpc_pkg::ST_BLOW_EXT)
                       || (state_q == vpc_pkg::ST_BLOW_INT); // [RL2] [RL4]
      o_vent_valve  <= (state_q == vpc_pkg::ST_BLOW_EXT)
                       || (state_q == vpc_pkg::ST_BLOW_INT); // [RL4]
    end
  end

  // Limit levels with hysteresis; independent of regulation and outputs
  logic upper_lvl_q;
  logic lower_lvl_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      upper_lvl_q <= 1'b0;
      lower_lvl_q <= 1'b0;
    end else begin
      if (above_up) begin
        upper_lvl_q <= 1'b1; // [RL5] [RL8]
      end else if (below_up_h) begin
        upper_lvl_q <= 1'b0; // [RL6]
      end
      if (above_lo) begin
        lower_lvl_q <= 1'b1; // [RL5] [RL8]
      end else if (below_lo_h) begin
        lower_lvl_q <= 1'b0; // [RL6]
      end
    end
  end

  // Blink phase for manual mode
  logic [7:0] blink_ms_q;
  logic       blink_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      blink_ms_q <= 8'h00;
      blink_q    <= 1'b0;
    end else if (ms_tick_q) begin
      if (blink_ms_q == 8'(`VPC_BLINK_MS - 1)) begin
        blink_ms_q <= 8'h00;
        blink_q    <= !blink_q;
      end else begin
        blink_ms_q <= blink_ms_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_led_upper <= 1'b0;
      o_led_lower <= 1'b0;
    end else if (ctrl_q[`VPC_CTRL_MANUAL]) begin
      o_led_upper <= blink_q; // [RL7]
      o_led_lower <= blink_q; // [RL7]
    end else begin
      o_led_upper <= upper_lvl_q; // [RL5] [RL8]
      o_led_lower <= lower_lvl_q; // [RL5] [RL8]
    end
  end

  // Switching output follows upper level after the set delay
  logic [7:0] dly_ms_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_sw_out <= 1'b0;
      dly_ms_q <= 8'h00;
    end else if (upper_lvl_q == o_sw_out) begin
      dly_ms_q <= 8'h00;
    end else if (ms_tick_q) begin
      if (dly_ms_q + 8'h01 >= out_dly_q) begin
        o_sw_out <= upper_lvl_q; // [RL11]
        dly_ms_q <= 8'h00;
      end else begin
        dly_ms_q <= dly_ms_q + 1'b1;
      end
    end
  end

  // Interrupt status: a new event beats a same-cycle clear
  logic       both_q;
  logic       upper_lvl_d1_q;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  assign irq_set[`VPC_IRQ_PLOSS]    = ploss_ev;
  assign irq_set[`VPC_IRQ_CONFLICT] = suck && blow && !both_q;
  assign irq_set[`VPC_IRQ_UPPER]    = upper_lvl_q && !upper_lvl_d1_q;
  assign irq_clr = (wr_go && aw_addr_q == `VPC_ADR_IRQ_STAT && wmask(w_strb_q, 0))
                   ? w_data_q[2:0] : 3'h0;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      both_q         <= 1'b0;
      upper_lvl_d1_q <= 1'b0;
      irq_stat_q     <= 3'h0;
      o_irq          <= 1'b0;
    end else begin
      both_q         <= suck && blow;
      upper_lvl_d1_q <= upper_lvl_q;
      irq_stat_q     <= (irq_stat_q & ~irq_clr) | irq_set;
      o_irq          <= |(irq_stat_q & irq_mask_q);
    end
  end

  // AXI4-Lite read path
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      `VPC_ADR_CTRL:     rd_val = {29'h0, ctrl_q};
      `VPC_ADR_UPPER:    rd_val = 32'(upper_q);
      `VPC_ADR_LOWER:    rd_val = 32'(lower_q);
      `VPC_ADR_HYST:     rd_val = 32'(hyst_q);
      `VPC_ADR_BLOW_MS:  rd_val = {16'h0, blow_ms_q};
      `VPC_ADR_OUT_DLY:  rd_val = {24'h0, out_dly_q};
      `VPC_ADR_STATUS:   rd_val = {16'h0, err_code_q, guard_q, o_sw_out, o_pump_on,
                                   upper_lvl_q, lower_lvl_q, 1'b0, state_q};
      `VPC_ADR_IRQ_STAT: rd_val = {29'h0, irq_stat_q};
      `VPC_ADR_IRQ_MASK: rd_val = {29'h0, irq_mask_q};
      default:           rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : vpc_top
`default_nettype wire

// file: verification/vpc_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
module vpc_plc_model (
  input  wire logic i_clk,
  input  wire logic i_slow,
  input  wire logic i_suck_req,
  input  wire logic i_blow_req,
  output logic      o_suction,
  output logic      o_blowoff
);
  logic [3:0] suck_q = 4'h0;
  logic [3:0] blow_q = 4'h0;

  // Both lines run through equal-depth pipes read at the same tap, so a joint request lands in one edge
  always_ff @(posedge i_clk) begin
    suck_q <= {suck_q[2:0], i_suck_req};
    blow_q <= {blow_q[2:0], i_blow_req};
  end

  // Slow controller lags its request by four cycles
  assign o_suction = i_slow ? suck_q[3] : suck_q[0];
  assign o_blowoff = i_slow ? blow_q[3] : blow_q[0];
endmodule : vpc_plc_model
`default_nettype wire

// file: verification/vpc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module vpc_top_asserts #(
  parameter int FILT_CYC = 300000
) (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_suction,
  input wire logic        i_blowoff,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        o_pump_on,
  input wire logic        o_vent_valve,
  input wire logic        o_led_suction,
  input wire logic        o_led_blowoff
);
  // Sync, filter, state and output stages plus margin
  localparam int LIM = FILT_CYC + 8;
  logic [1:0] cmd_q;
  int         stab_q;
  logic       settled;

  always_ff @(posedge i_clk) begin
    cmd_q <= {i_suction, i_blowoff};
    if (i_sys_rst || cmd_q != {i_suction, i_blowoff}) begin
      stab_q <= 0;
    end else if (stab_q < LIM) begin
      stab_q <= stab_q + 1;
    end
  end
  // Drops in the very edge an input moves, before the counter sees it
  assign settled = (stab_q == LIM) && (cmd_q == {i_suction, i_blowoff});

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_blow_wins: assert property (
    settled && i_blowoff |-> o_led_blowoff && !o_led_suction)
    else $error("blowoff command not dominant");
  a_suck_led: assert property (
    settled && i_suction && !i_blowoff |-> o_led_suction && !o_led_blowoff)
    else $error("suction indicator missing");
  a_pump_idle: assert property (
    settled && !i_suction && !i_blowoff |-> !o_pump_on && !o_led_suction)
    else $error("pump or suction indicator on while released");
  a_pump_led: assert property (
    $rose(o_pump_on) |-> ##[0:2] o_led_suction)
    else $error("pump started outside suction");
  a_vent_led: assert property (
    o_vent_valve == o_led_blowoff && !(o_vent_valve && o_pump_on))
    else $error("vent valve and blowoff indicator differ");
  a_wr_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
  a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_bad_addr: assert property (
    s_rd_take ##0 (s_axi_araddr > 8'h20 || s_axi_araddr[1:0] != 2'h0)
    |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
endmodule : vpc_top_asserts

bind vpc_top vpc_top_asserts #(.FILT_CYC(FILT_CYC)) u_chk (
  .i_clk, .i_sys_rst, .i_suction, .i_blowoff,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rresp, .s_axi_rvalid,
  .o_pump_on, .o_vent_valve, .o_led_suction, .o_led_blowoff
);
`default_nettype wire

// file: verification/vpc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vpc_top_tb_top;
  localparam int FC  = 8;
  localparam int SET = FC + 12;
  localparam logic [7:0]  RA [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
  localparam logic [31:0] RV [7] = '{32'h1, 32'h1f4, 32'hc8, 32'h14, 32'hc8, 32'ha, 32'h0};
  localparam logic [9:0]  VT [8] = '{10'h064, 10'h0fa, 10'h136, 10'h118, 10'h10d,
                                     10'h0b9, 10'h0b3, 10'h0c8};
  localparam logic [1:0]  LT [8] = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h1, 2'h1, 2'h0, 2'h0};
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, slow = 1'b0;
  logic        suck_req = 1'b0, blow_req = 1'b0, i_suction, i_blowoff;
  logic [9:0]  i_vacuum = 10'h000;
  logic        i_supply_ok = 1'b1, i_serial_mode = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        o_pump_on, o_vent_valve, o_led_suction, o_led_blowoff;
  logic        o_led_upper, o_led_lower, o_sw_out, o_irq;
  int          miscompares = 0, n_checks = 0, cyc = 0, hu = 0, hl = 0;

  vpc_plc_model plc (.i_clk, .i_slow(slow), .i_suck_req(suck_req), .i_blow_req(blow_req),
                     .o_suction(i_suction), .o_blowoff(i_blowoff));
  vpc_top #(.VAC_W(10), .MS_CYC(10), .FILT_CYC(FC)) dut (
    .i_clk, .i_sys_rst, .i_suction, .i_blowoff, .i_vacuum, .i_supply_ok, .i_serial_mode,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .o_pump_on, .o_vent_valve, .o_led_suction,
    .o_led_blowoff, .o_led_upper, .o_led_lower, .o_sw_out, .o_irq);

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task automatic conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // Whole run is about 6400 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t %s: got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : rd_reg

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    rd_reg(a);
    chk(rd, e, m);
  endtask : rchk

  // Order: suction led, blowoff led, pump, vent
  task automatic outs(input logic [3:0] e, input string m);
    chk(32'({o_led_suction, o_led_blowoff, o_pump_on, o_vent_valve}), 32'(e), m);
  endtask : outs

  initial begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) rchk(RA[i], RV[i], "reset value");
    rd_reg(8'h24);
    chk(32'(rs), 32'h2, "unmapped resp");
    wr(8'h24, 32'h0);
    chk(32'(rs), 32'h2, "unmapped write resp");
    wr(8'h04, 32'h12c);
    rchk(8'h04, 32'h1f4, "write outside serial mode");
    i_serial_mode <= 1'b1;
    wr(8'h04, 32'h12c);
    rchk(8'h04, 32'h12c, "remote write");
    wr(8'h14, 32'h0);
    rchk(8'h14, 32'h1, "delay low clamp");
    wr(8'h14, 32'hff);
    rchk(8'h14, 32'hc8, "delay high clamp");
    wr(8'h14, 32'h2);
    i_vacuum <= 10'h136;
    repeat (4) @(posedge i_clk);
    chk(32'(o_sw_out), 32'h0, "switch output early");
    repeat (40) @(posedge i_clk);
    chk(32'(o_sw_out), 32'h1, "switch output late");
    for (int i = 0; i < 8; i++) begin
      i_vacuum <= VT[i];
      repeat (4) @(posedge i_clk);
      chk(32'({o_led_upper, o_led_lower}), 32'(LT[i]), "limit leds");
    end
    wr(8'h00, 32'h3);
    for (int k = 0; k < 60; k++) begin
      repeat (100) @(posedge i_clk);
      if (o_led_upper === 1'b1) hu++;
      if (o_led_lower === 1'b1) hl++;
    end
    chk(32'(hu > 20 && hu < 40 && hl > 20 && hl < 40), 32'h1, "manual flash");
    wr(8'h00, 32'h1);
    i_vacuum <= 10'h000;
    suck_req <= 1'b1;
    repeat (SET) @(posedge i_clk);
    outs(4'ha, "suction start");
    i_vacuum <= 10'h136;
    repeat (6) @(posedge i_clk);
    outs(4'h8, "pump stops at upper");
    i_vacuum <= 10'h113;
    repeat (6) @(posedge i_clk);
    outs(4'h8, "pump holds in band");
    i_vacuum <= 10'h10d;
    repeat (6) @(posedge i_clk);
    outs(4'ha, "pump restarts");
    slow <= 1'b1;
    blow_req <= 1'b1;
    repeat (SET + 4) @(posedge i_clk);
    outs(4'h5, "both commands");
    rd_reg(8'h1c);
    chk(32'(rd[1]), 32'h1, "conflict event");
    wr(8'h1c, 32'h7);
    suck_req <= 1'b0;
    blow_req <= 1'b0;
    slow <= 1'b0;
    repeat (SET) @(posedge i_clk);
    outs(4'h0, "standby");
    wr(8'h10, 32'h3);
    wr(8'h00, 32'h5);
    suck_req <= 1'b1;
    repeat (SET) @(posedge i_clk);
    suck_req <= 1'b0;
    repeat (SET) @(posedge i_clk);
    outs(4'h5, "timed blowoff running");
    repeat (40) @(posedge i_clk);
    outs(4'h0, "timed blowoff over");
    wr(8'h20, 32'h1);
    wr(8'h04, 32'h12c);
    i_supply_ok <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_supply_ok <= 1'b1;
    rd_reg(8'h18);
    chk(32'(rd[15:8]), 32'h1, "loss error code");
    chk(32'(o_irq), 32'h1, "loss interrupt");
    wr(8'h20, 32'h0);
    repeat (3) @(posedge i_clk);
    chk(32'(o_irq), 32'h0, "masked interrupt");
    wr(8'h1c, 32'h1);
    rd_reg(8'h1c);
    chk(32'(rd[0]), 32'h0, "event cleared");
    conclude();
  end
endmodule : vpc_top_tb_top
`default_nettype wire
